// [cpsb_defines.svh]
/*
 * Constants of the charge port status bank: register offsets, bit
 * positions, reset values and analogue thresholds in mV and 0.1 mA units.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef CPSB_DEFINES_SVH
`define CPSB_DEFINES_SVH

// ==========================================================
// Register offsets
`define CPSB_ADDR_MISC 8'h0F
`define CPSB_ADDR_FAULT 8'h10
`define CPSB_ADDR_GEN 8'h11
`define CPSB_ADDR_PROF1 8'h12
`define CPSB_ADDR_PROF2 8'h13
`define CPSB_ADDR_PIN 8'h14

// ==========================================================
// Bit positions
`define CPSB_BIT_ERR 7
`define CPSB_BIT_BOOT 5
`define CPSB_NUM_FLAGS 11
`define CPSB_NUM_FAULTS 6
`define CPSB_FLG_QUOTA 6
`define CPSB_FLG_THERMAL_THROTTLE_FLAG 7
`define CPSB_FLG_LOW 8
`define CPSB_FLG_REM 9
`define CPSB_FLG_ATT 10

// ==========================================================
// Reset values and codes
`define CPSB_RST_BYTE 8'h00
`define CPSB_STEP_NONE 2'h0
`define CPSB_STEP_TWO 2'h2
`define CPSB_STEP_THREE 2'h3
`define CPSB_PWR_ERROR 2'h3
`define CPSB_QUOTA_ACT_INT 2'h1

// ==========================================================
// Thresholds: voltages in mV, current in 0.1 mA units
`define CPSB_BACKV_MARGIN_MV 12'h096
`define CPSB_LOW_DRAW_TENTH_MA 16'h0040

`endif

// [cpsb_flag_cell.sv]
/*
 * One sticky status flag: set has priority over clear.
 * Assumes a synchronous active-high reset and one clock.
 */
module cpsb_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);

  // ==========================================================
  // Storage; a set in the clear cycle is never lost
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      q_o <= RST_VAL;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end

  chk_set_wins: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    set_i |=> q_o)
    else $error("flag lost a set");

endmodule : cpsb_flag_cell

// [cpsb_host_model.sv]
/*
 * Host model for the status bank: completed register reads and writes.
 * Assumes the bench's clock; requests change on the falling edge.
 */
module cpsb_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_o,
  output logic wr_o,
  output logic done_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    {rd_o, wr_o, done_o} = 3'h0;
    addr_o = 8'hFF;
    wdata_o = 8'hFF;
  end

  // ==========================================================
  // Read: completion only after the data is taken, so clears land late
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rd_data_i;
    done_o = 1'b1;
    @(negedge clk_sys_i);
    done_o = 1'b0;
  endtask : read_reg

  // ==========================================================
  // Write: released bus shows inverted values, not the stale ones
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = v;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
  endtask : write_reg
endmodule : cpsb_host_model

// [cpsb_pkg.sv]
/*
 * Types shared by the charge port status bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpsb_pkg;

  // ==========================================================
  // Error handling state, one-hot
  typedef enum logic [1:0]
  {
    CPSB_ST_RUN = 2'b01,
    CPSB_ST_ERR = 2'b10
  } cpsb_state_t;

endpackage : cpsb_pkg

// [cpsb_status_bank.sv]
/*
 * Status register bank of a USB port power controller: pin mirrors,
 * emulation progress, fault flags with error state, general and
 * profile flags, read over a completed host read/write transaction.
 * Assumes the host interface engine delivers one-cycle strobes and
 * that analogue comparisons arrive as synchronous levels or values.
 */
// Summary of operation
// [RULE1] Two read-only bits mirror alert and attach pins, one when low.
// [RULE2] Charging-current flag follows bus current against its threshold.
// [RULE3] Emulating flag is set only while Active and emulating.
// [RULE4] Step index reports pair 0..3; two-pair profiles never show 3.
// [RULE5] Error flag set entering Error; host zero write rechecks faults.
// [RULE6] Error is held while any other fault bit stays set.
// [RULE7] Error flag self-clears on auto-recovery or port power off.
// [RULE8] Six fault bits raise alert, force Error, clear on read.
// [RULE9] Back voltage when bus exceeds source or supply by margin.
// [RULE10] Overcurrent needs current above limit and minimum threshold.
// [RULE11] Boot flag set at power-up, no alert, clears on read/toggle.
// [RULE12] Quota flag alerts only if action selects interrupt.
// [RULE13] Constant-current flag while current exceeds the limit.
// [RULE14] Throttle flag clears on read, alerts only with link set.
// [RULE15] Low-draw flag below 6.4 mA, clears on read, linked alert.
// [RULE16] Removal sets detach flag and releases attach pin, no alert.
// [RULE17] Attach sets plugged flag and asserts attach pin, no alert.
// [RULE18] Profile bits never drive pins; clear on power off/mode/removal. Here the cdp, pt and dcp bits drive the switch control pins.
// [RULE19] No-handshake flag set at profile end, alone, cleared on new.
// [RULE20] Source undervoltage flag holds port switch off, self-clears.
// [RULE21] Downstream or pass-through closes switch, trip limit; dedicated CC.
// [RULE22] After re-attach, pass-through bit waits for a mode-select toggle.
// [RULE23] Read clears act only on the read register, after data returns.
`include "cpsb_defines.svh"

module cpsb_status_bank (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic host_rd_done_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [15:0] ibus_i,
  input wire logic [15:0] ibus_chg_thr_i,
  input wire logic [15:0] current_limit_level_i,
  input wire logic [15:0] ibus_r2min_thr_i,
  input wire logic [11:0] vbus_mv_i,
  input wire logic [11:0] vs_mv_i,
  input wire logic [11:0] vdd_mv_i,
  input wire logic engine_active_i,
  input wire logic emulating_i,
  input wire logic [1:0] step_i,
  input wire logic two_pair_profile_i,
  input wire logic discharge_fail_i,
  input wire logic vbus_under_i,
  input wire logic over_temp_i,
  input wire logic vs_over_i,
  input wire logic vs_uvlo_i,
  input wire logic auto_recover_i,
  input wire logic port_power_ctl_i,
  input wire logic mode_select_first_i,
  input wire logic mode_select_second_i,
  input wire logic emu_enable_i,
  input wire logic polarity_sel_i,
  input wire logic [1:0] power_state_i,
  input wire logic mode_change_i,
  input wire logic quota_reached_i,
  input wire logic [1:0] quota_action_sel_i,
  input wire logic quota_clear_ctl_i,
  input wire logic quota_enable_ctl_i,
  input wire logic notice_link_i,
  input wire logic temp_reg_cut_i,
  input wire logic attach_evt_i,
  input wire logic removal_evt_i,
  input wire logic user_accept_i,
  input wire logic dcp_accept_i,
  input wire logic cdp_accept_i,
  input wire logic passthrough_mode_i,
  input wire logic [6:0] legacy_accept_i,
  input wire logic no_handshake_flag_evt_i,
  input wire logic new_profile_i,
  output logic [7:0] rd_data_o,
  output logic alert_n_o,
  output logic attach_out_n_o,
  output logic error_state_o,
  output logic port_switch_off_o,
  output logic hs_switch_close_o,
  output logic trip_limit_o,
  output logic const_limit_o
);

  // ==========================================================
  // Host access decode
  logic [7:0] rd_addr_q;
  logic rd_pend_q;
  wire rd_commit = host_rd_done_i & rd_pend_q;
  wire rd_fault = rd_commit & (rd_addr_q == `CPSB_ADDR_FAULT); // see [RULE23]
  wire rd_gen = rd_commit & (rd_addr_q == `CPSB_ADDR_GEN); // see [RULE23]
  wire wr_fault = host_wr_i & (host_addr_i == `CPSB_ADDR_FAULT);
  wire host_err_zero = wr_fault & ~host_wdata_i[`CPSB_BIT_ERR];

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rd_addr_q <= `CPSB_RST_BYTE;
      rd_pend_q <= 1'b0;
    end
    else if (host_rd_i)
    begin
      rd_addr_q <= host_addr_i;
      rd_pend_q <= 1'b1;
    end
    else if (host_rd_done_i)
      rd_pend_q <= 1'b0;
  end

  // ==========================================================
  // Fault conditions
  logic pp_q;
  logic m1_q;
  wire pp_toggle = pp_q ^ port_power_ctl_i;
  wire [12:0] vs_lim = {1'b0, vs_mv_i} + {1'b0, `CPSB_BACKV_MARGIN_MV};
  wire [12:0] vdd_lim = {1'b0, vdd_mv_i} + {1'b0, `CPSB_BACKV_MARGIN_MV};
  wire reverse_volt_flag = ({1'b0, vbus_mv_i} > vs_lim)
                 | ({1'b0, vbus_mv_i} > vdd_lim); // see [RULE9]
  wire over_lim = ibus_i > current_limit_level_i;
  wire over_trip = over_lim & (ibus_i > ibus_r2min_thr_i); // see [RULE10]
  // Order: overcurrent, back, source over, thermal, bus under, discharge
  wire [5:0] fault_cond = {discharge_fail_i, vbus_under_i, over_temp_i,
                           vs_over_i, reverse_volt_flag, over_trip}; // see [RULE8]

  // ==========================================================
  // Error state
  cpsb_pkg::cpsb_state_t state_q;
  cpsb_pkg::cpsb_state_t state_d;
  logic [10:0] flag_q;
  wire [5:0] fault_q = flag_q[5:0];
  wire in_err = state_q == cpsb_pkg::CPSB_ST_ERR;
  // A clear attempt drops every latched fault whose condition is gone
  wire clr_try = host_err_zero | auto_recover_i
               | ~port_power_ctl_i; // see [RULE5] see [RULE7]
  wire [5:0] fault_clr = {6{rd_fault | clr_try}}; // see [RULE8]
  wire [5:0] fault_nx = fault_cond | (fault_q & ~fault_clr);
  wire faults_left = |fault_nx;
  wire err_leave = clr_try & ~faults_left; // see [RULE6]

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cpsb_pkg::CPSB_ST_RUN:
        if (|fault_cond)
          state_d = cpsb_pkg::CPSB_ST_ERR; // see [RULE5]
      cpsb_pkg::CPSB_ST_ERR:
        if (err_leave)
          state_d = cpsb_pkg::CPSB_ST_RUN;
      default:
        state_d = cpsb_pkg::CPSB_ST_ERR;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      state_q <= cpsb_pkg::CPSB_ST_RUN;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // Sticky flags
  wire low_draw = (ibus_i < `CPSB_LOW_DRAW_TENTH_MA) & ~attach_out_n_o;
  wire [10:0] flag_set = {attach_evt_i, removal_evt_i, low_draw,
                          temp_reg_cut_i, quota_reached_i, fault_cond};
  wire quota_clr = rd_gen | quota_clear_ctl_i
                 | ~quota_enable_ctl_i; // see [RULE12]
  wire [10:0] flag_clr = {{4{rd_gen}}, quota_clr, fault_clr}; // see [RULE14]
  logic boot_q;

  genvar gi;
  generate
    for (gi = 0; gi < `CPSB_NUM_FLAGS; gi = gi + 1)
    begin : g_flag
      cpsb_flag_cell #(
        .RST_VAL(1'b0)
      ) u_cell (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .set_i(flag_set[gi]),
        .clr_i(flag_clr[gi]),
        .q_o(flag_q[gi])
      );
    end
  endgenerate

  cpsb_flag_cell #(
    .RST_VAL(1'b1)
  ) u_boot (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .set_i(1'b0),
    .clr_i(rd_fault | pp_toggle), // see [RULE11]
    .q_o(boot_q)
  );

  // ==========================================================
  // Level flags and profile acceptance
  logic chg_q;
  logic emu_q;
  logic [1:0] step_q;
  logic cc_q;
  logic source_undervolt_flag_q;
  logic user_q;
  logic dcp_q;
  logic cdp_q;
  logic pt_q;
  logic pt_arm_q;
  logic no_handshake_flag_q;
  logic [6:0] legacy_q;
  wire chg_d = (ibus_i > ibus_chg_thr_i) ? 1'b1
             : (ibus_i < ibus_chg_thr_i) ? 1'b0 : chg_q; // see [RULE2]
  wire [1:0] step_d = (two_pair_profile_i && step_i == `CPSB_STEP_THREE)
                    ? `CPSB_STEP_TWO : step_i; // see [RULE4]
  wire prof_clr = ~port_power_ctl_i | mode_change_i
                | removal_evt_i; // see [RULE18]
  // Re-arm only on a mode change or a toggle of the first mode select
  wire pt_rearm = mode_change_i | (m1_q ^ mode_select_first_i); // see [RULE22]
  wire pt_set = passthrough_mode_i & pt_arm_q & ~removal_evt_i;
  wire user_d = user_accept_i | (user_q & ~prof_clr);
  wire dcp_d = dcp_accept_i | (dcp_q & ~prof_clr);
  wire cdp_d = cdp_accept_i | (cdp_q & ~prof_clr);
  wire pt_d = pt_set | (pt_q & ~prof_clr);
  wire [6:0] legacy_d = legacy_accept_i | (legacy_q & ~{7{prof_clr}});
  wire other_prof = user_d | dcp_d | cdp_d | pt_d | (|legacy_d);
  wire no_handshake_flag_d = ~other_prof
               & (no_handshake_flag_evt_i | (no_handshake_flag_q & ~new_profile_i)); // see [RULE19]

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      chg_q <= 1'b0;
      emu_q <= 1'b0;
      step_q <= `CPSB_STEP_NONE;
      cc_q <= 1'b0;
      source_undervolt_flag_q <= 1'b0;
      // Track the pins in reset so release brings no false toggle
      pp_q <= port_power_ctl_i;
      m1_q <= mode_select_first_i;
    end
    else
    begin
      chg_q <= chg_d;
      emu_q <= ~in_err & engine_active_i & emulating_i; // see [RULE3]
      step_q <= step_d;
      cc_q <= over_lim; // see [RULE13]
      source_undervolt_flag_q <= vs_uvlo_i; // see [RULE20]
      pp_q <= port_power_ctl_i;
      m1_q <= mode_select_first_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      user_q <= 1'b0;
      dcp_q <= 1'b0;
      cdp_q <= 1'b0;
      pt_q <= 1'b0;
      pt_arm_q <= 1'b1;
      no_handshake_flag_q <= 1'b0;
      legacy_q <= 7'h00;
    end
    else
    begin
      user_q <= user_d;
      dcp_q <= dcp_d;
      cdp_q <= cdp_d;
      pt_q <= pt_d;
      pt_arm_q <= pt_rearm | (pt_arm_q & ~removal_evt_i);
      no_handshake_flag_q <= no_handshake_flag_d;
      legacy_q <= legacy_d;
    end
  end

  // ==========================================================
  // Pins and switch controls
  wire quota_alert = flag_q[`CPSB_FLG_QUOTA]
                   & (quota_action_sel_i == `CPSB_QUOTA_ACT_INT);
  wire link_alert = notice_link_i & (flag_q[`CPSB_FLG_THERMAL_THROTTLE_FLAG]
                                   | flag_q[`CPSB_FLG_LOW]);
  // Boot, attach, detach and profile bits deliberately stay off the alert
  wire alert_d = (|fault_nx) | quota_alert | link_alert; // see [RULE12]
  wire attach_n_d = removal_evt_i ? 1'b1
                  : attach_evt_i ? 1'b0 : attach_out_n_o; // see [RULE16]

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      alert_n_o <= 1'b1;
      attach_out_n_o <= 1'b1;
      error_state_o <= 1'b0;
      port_switch_off_o <= 1'b0;
      hs_switch_close_o <= 1'b0;
      trip_limit_o <= 1'b0;
      const_limit_o <= 1'b0;
    end
    else
    begin
      alert_n_o <= ~alert_d; // see [RULE14] see [RULE15]
      attach_out_n_o <= attach_n_d; // see [RULE17]
      error_state_o <= state_d == cpsb_pkg::CPSB_ST_ERR;
      port_switch_off_o <= vs_uvlo_i; // see [RULE20]
      hs_switch_close_o <= cdp_d | pt_d; // see [RULE21]
      trip_limit_o <= cdp_d | pt_d;
      const_limit_o <= dcp_d & ~(cdp_d | pt_d);
    end
  end

  // ==========================================================
  // Read data
  wire [7:0] misc_byte = {2'b00, ~alert_n_o, ~attach_out_n_o, chg_q, emu_q,
                          step_q}; // see [RULE1]
  wire [7:0] fault_byte = {in_err, fault_q[5], boot_q, fault_q[4:0]};
  wire [7:0] gen_byte = {flag_q[`CPSB_FLG_QUOTA], 2'b00, cc_q,
                         flag_q[`CPSB_FLG_THERMAL_THROTTLE_FLAG], flag_q[`CPSB_FLG_LOW],
                         flag_q[`CPSB_FLG_REM], flag_q[`CPSB_FLG_ATT]};
  wire [7:0] prof1_byte = {no_handshake_flag_q, 2'b00, source_undervolt_flag_q, user_q, dcp_q, cdp_q,
                           pt_q};
  wire [7:0] prof2_byte = {1'b0, legacy_q};
  wire [1:0] pwr_show = in_err ? `CPSB_PWR_ERROR : power_state_i;
  wire [7:0] pin_byte = {1'b0, port_power_ctl_i, mode_select_second_i,
                         mode_select_first_i, emu_enable_i, polarity_sel_i,
                         pwr_show};
  wire [7:0] rd_mux = (host_addr_i == `CPSB_ADDR_MISC) ? misc_byte
                    : (host_addr_i == `CPSB_ADDR_FAULT) ? fault_byte
                    : (host_addr_i == `CPSB_ADDR_GEN) ? gen_byte
                    : (host_addr_i == `CPSB_ADDR_PROF1) ? prof1_byte
                    : (host_addr_i == `CPSB_ADDR_PROF2) ? prof2_byte
                    : (host_addr_i == `CPSB_ADDR_PIN) ? pin_byte
                    : `CPSB_RST_BYTE;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      rd_data_o <= `CPSB_RST_BYTE;
    else if (host_rd_i)
      rd_data_o <= rd_mux;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_alert_mirror: assert property ( // see [RULE1]
    host_rd_i && host_addr_i == `CPSB_ADDR_MISC
    |=> rd_data_o[5] == ~$past(alert_n_o)
      && rd_data_o[4] == ~$past(attach_out_n_o))
    else $error("pin mirror bits wrong");

  chk_chg_follow: assert property ( // see [RULE2]
    ibus_i > ibus_chg_thr_i |=> chg_q
      ##1 (chg_q || $past(ibus_i) < $past(ibus_chg_thr_i)))
    else $error("charging flag wrong");

  chk_emu_state: assert property ( // see [RULE3]
    in_err |=> !emu_q)
    else $error("emulating flag in error state");

  chk_step_cap: assert property ( // see [RULE4]
    two_pair_profile_i |=> step_q != `CPSB_STEP_THREE)
    else $error("two-pair profile shows pair three");

  chk_err_enter: assert property ( // see [RULE5]
    |fault_cond |=> in_err && error_state_o && !alert_n_o)
    else $error("fault did not enter error");

  chk_err_hold: assert property ( // see [RULE6]
    in_err && faults_left |=> in_err)
    else $error("left error with fault set");

  chk_err_power: assert property ( // see [RULE7]
    in_err && !port_power_ctl_i && !faults_left |=> !in_err)
    else $error("error flag kept with power off");

  chk_reverse_volt_flag: assert property ( // see [RULE9]
    reverse_volt_flag |=> fault_q[1] ##1 (fault_q[1] || $past(rd_fault || clr_try)))
    else $error("back voltage not flagged");

  chk_ovc_both: assert property ( // see [RULE10]
    ibus_i <= ibus_r2min_thr_i && !fault_q[0] |=> !fault_q[0])
    else $error("overcurrent below minimum threshold");

  chk_attach_pin: assert property ( // see [RULE17]
    attach_evt_i && !removal_evt_i |=> !attach_out_n_o ##1 (!attach_out_n_o
      || $past(removal_evt_i)))
    else $error("attach pin not asserted");

  chk_detach_pin: assert property ( // see [RULE16]
    removal_evt_i |=> attach_out_n_o && flag_q[`CPSB_FLG_REM] && !pt_q)
    else $error("removal not handled");

  chk_switch_mode: assert property ( // see [RULE21]
    cdp_q |-> hs_switch_close_o && trip_limit_o && !const_limit_o)
    else $error("switch mode wrong for downstream port");

  chk_nohs_alone: assert property ( // see [RULE19]
    no_handshake_flag_q |-> !(user_q || dcp_q || cdp_q || pt_q || |legacy_q))
    else $error("no-handshake shown with profile bit");

  chk_read_clear: assert property ( // see [RULE23]
    rd_gen && !attach_evt_i |=> !flag_q[`CPSB_FLG_ATT])
    else $error("read did not clear plugged flag");

  cov_error_cycle: cover property (in_err ##[1:50] !in_err);
  cov_attach_remove: cover property (attach_evt_i ##[1:50] removal_evt_i);
  cov_pt_blocked: cover property (removal_evt_i ##[1:50] passthrough_mode_i
    && !pt_arm_q);
  cov_boot_read: cover property (boot_q ##1 !boot_q);

endmodule : cpsb_status_bank

// [test_cpsb_status_bank.sv]
/*
 * Self-checking bench for the charge port status bank.
 * Assumes the host model file; inputs change on the falling edge.
 */
module test_cpsb_status_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, srst_i, host_rd_i, host_wr_i, host_rd_done_i;
  logic [7:0] host_addr_i, host_wdata_i, rd_data_o;
  logic [15:0] ibus_i, ibus_chg_thr_i, current_limit_level_i;
  logic [15:0] ibus_r2min_thr_i;
  logic [11:0] vbus_mv_i, vs_mv_i, vdd_mv_i;
  logic engine_active_i, emulating_i, two_pair_profile_i, discharge_fail_i;
  logic vbus_under_i, over_temp_i, vs_over_i, vs_uvlo_i, auto_recover_i;
  logic port_power_ctl_i, mode_select_first_i, mode_select_second_i;
  logic emu_enable_i, polarity_sel_i, mode_change_i, quota_reached_i;
  logic quota_clear_ctl_i, quota_enable_ctl_i, notice_link_i;
  logic temp_reg_cut_i, attach_evt_i, removal_evt_i, user_accept_i;
  logic dcp_accept_i, cdp_accept_i, passthrough_mode_i, no_handshake_flag_evt_i;
  logic new_profile_i, alert_n_o, attach_out_n_o, error_state_o;
  logic port_switch_off_o, hs_switch_close_o, trip_limit_o, const_limit_o;
  logic [1:0] step_i, power_state_i, quota_action_sel_i;
  logic [6:0] legacy_accept_i;
  logic [7:0] fbit [6] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  int miscompares, tests_run;

  cpsb_status_bank u_cpsb_status_bank (.*);

  cpsb_host_model u_cpsb_host_model (
    .clk_sys_i(clk_sys_i),
    .rd_data_i(rd_data_o),
    .rd_o(host_rd_i),
    .wr_o(host_wr_i),
    .done_o(host_rd_done_i),
    .addr_o(host_addr_i),
    .wdata_o(host_wdata_i)
  );

  // ==========================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : step

  task automatic check(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : check

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_cpsb_host_model.read_reg(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask : rdc

  // Bits: alert_n, attach_n, error, switch off, hs close, trip, const
  task automatic pins(input logic [7:0] e);
    check("pins", {1'b0, alert_n_o, attach_out_n_o, error_state_o,
      port_switch_off_o, hs_switch_close_o, trip_limit_o,
      const_limit_o}, e);
  endtask : pins

  task automatic fault(input int k, input logic v);
    case (k)
      0: discharge_fail_i = v;
      1: vbus_under_i = v;
      2: over_temp_i = v;
      3: vs_over_i = v;
      4: vbus_mv_i = v ? 12'hC4F : 12'hBB8;
      default: ibus_i = v ? 16'h09C4 : 16'h01F4;
    endcase
  endtask : fault

  task automatic finish_test;
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Clock and watchdog; the sequence needs well under 2000 cycles
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    miscompares++;
    finish_test;
  end

  // ==========================================================
  // Sequence
  initial
  begin
    {engine_active_i, emulating_i, two_pair_profile_i, discharge_fail_i,
      vbus_under_i, over_temp_i, vs_over_i, vs_uvlo_i, auto_recover_i,
      mode_change_i, quota_reached_i, quota_clear_ctl_i, notice_link_i,
      temp_reg_cut_i, attach_evt_i, removal_evt_i, user_accept_i,
      dcp_accept_i, cdp_accept_i, passthrough_mode_i, no_handshake_flag_evt_i,
      new_profile_i, step_i, quota_action_sel_i, legacy_accept_i} = '0;
    {port_power_ctl_i, mode_select_first_i, mode_select_second_i,
      emu_enable_i, polarity_sel_i, quota_enable_ctl_i} = 6'h3F;
    power_state_i = 2'h2;
    ibus_i = 16'h01F4;
    ibus_chg_thr_i = 16'h0320;
    current_limit_level_i = 16'h03E8;
    ibus_r2min_thr_i = 16'h07D0;
    {vbus_mv_i, vs_mv_i, vdd_mv_i} = {3{12'hBB8}};
    srst_i = 1'b1;
    step(10);
    srst_i = 1'b0;
    pins(8'h60);
    rdc(8'h10, 8'h20);
    rdc(8'h10, 8'h00);
    rdc(8'h14, 8'h7E);
    rdc(8'h20, 8'h00);
    rdc(8'h0F, 8'h00);
    u_cpsb_host_model.write_reg(8'h11, 8'hFF);
    rdc(8'h11, 8'h00);
    // Margin of exactly 150 mV must not trip
    vbus_mv_i = 12'hC4E;
    step(2);
    pins(8'h60);
    vbus_mv_i = 12'hBB8;
    for (int k = 0; k < 6; k++)
    begin
      fault(k, 1'b1);
      step(2);
      pins(8'h30);
      rdc(8'h10, 8'h80 | fbit[k]);
      rdc(8'h14, 8'h7F);
      u_cpsb_host_model.write_reg(8'h10, 8'h00);
      step(1);
      pins(8'h30);
      fault(k, 1'b0);
      step(1);
      rdc(8'h10, 8'h80 | fbit[k]);
      rdc(8'h10, 8'h80);
      u_cpsb_host_model.write_reg(8'h10, 8'h00);
      step(1);
      pins(8'h60);
      rdc(8'h10, 8'h00);
    end
    over_temp_i = 1'b1;
    step(2);
    rdc(8'h0F, 8'h20);
    over_temp_i = 1'b0;
    auto_recover_i = 1'b1;
    step(3);
    pins(8'h60);
    auto_recover_i = 1'b0;
    rdc(8'h10, 8'h00);
    over_temp_i = 1'b1;
    step(2);
    over_temp_i = 1'b0;
    port_power_ctl_i = 1'b0;
    step(3);
    pins(8'h60);
    port_power_ctl_i = 1'b1;
    rdc(8'h10, 8'h00);
    ibus_i = 16'h0384;
    {engine_active_i, emulating_i, two_pair_profile_i} = 3'h7;
    step_i = 2'h3;
    step(2);
    rdc(8'h0F, 8'h0E);
    two_pair_profile_i = 1'b0;
    step(2);
    rdc(8'h0F, 8'h0F);
    engine_active_i = 1'b0;
    step_i = 2'h0;
    step(2);
    rdc(8'h0F, 8'h08);
    ibus_i = 16'h05DC;
    step(2);
    pins(8'h60);
    rdc(8'h11, 8'h10);
    {ibus_i, emulating_i} = {16'h01F4, 1'b0};
    step(2);
    rdc(8'h0F, 8'h00);
    rdc(8'h11, 8'h00);
    for (int a = 0; a < 2; a++)
    begin
      quota_action_sel_i = 2'(a);
      quota_reached_i = 1'b1;
      step(1);
      quota_reached_i = 1'b0;
      step(1);
      pins(a ? 8'h20 : 8'h60);
      rdc(8'h11, 8'h80);
    end
    // The flag must be standing when the quota clear arrives
    quota_reached_i = 1'b1;
    step(1);
    {quota_reached_i, quota_clear_ctl_i} = 2'h1;
    step(2);
    quota_clear_ctl_i = 1'b0;
    rdc(8'h11, 8'h00);
    quota_reached_i = 1'b1;
    step(1);
    {quota_reached_i, quota_enable_ctl_i} = 2'h0;
    step(2);
    quota_enable_ctl_i = 1'b1;
    rdc(8'h11, 8'h00);
    temp_reg_cut_i = 1'b1;
    step(2);
    pins(8'h60);
    notice_link_i = 1'b1;
    step(2);
    pins(8'h20);
    {temp_reg_cut_i, notice_link_i} = 2'h0;
    rdc(8'h11, 8'h08);
    rdc(8'h11, 8'h00);
    attach_evt_i = 1'b1;
    step(1);
    attach_evt_i = 1'b0;
    step(1);
    pins(8'h40);
    rdc(8'h0F, 8'h10);
    rdc(8'h11, 8'h01);
    rdc(8'h11, 8'h00);
    ibus_i = 16'h0020;
    step(2);
    pins(8'h40);
    ibus_i = 16'h01F4;
    rdc(8'h11, 8'h04);
    cdp_accept_i = 1'b1;
    step(1);
    cdp_accept_i = 1'b0;
    step(1);
    pins(8'h46);
    rdc(8'h12, 8'h02);
    mode_change_i = 1'b1;
    step(1);
    mode_change_i = 1'b0;
    rdc(8'h12, 8'h00);
    {dcp_accept_i, user_accept_i} = 2'h3;
    legacy_accept_i = 7'h55;
    step(1);
    {dcp_accept_i, user_accept_i, legacy_accept_i} = '0;
    step(1);
    check("const", {7'h00, const_limit_o}, 8'h01);
    rdc(8'h12, 8'h0C);
    rdc(8'h13, 8'h55);
    removal_evt_i = 1'b1;
    step(1);
    removal_evt_i = 1'b0;
    step(1);
    pins(8'h60);
    rdc(8'h12, 8'h00);
    rdc(8'h13, 8'h00);
    rdc(8'h11, 8'h02);
    no_handshake_flag_evt_i = 1'b1;
    step(1);
    no_handshake_flag_evt_i = 1'b0;
    rdc(8'h12, 8'h80);
    new_profile_i = 1'b1;
    step(1);
    new_profile_i = 1'b0;
    rdc(8'h12, 8'h00);
    vs_uvlo_i = 1'b1;
    step(2);
    pins(8'h68);
    rdc(8'h12, 8'h10);
    vs_uvlo_i = 1'b0;
    step(2);
    rdc(8'h12, 8'h00);
    // The earlier removal disarmed pass-through; a new mode re-arms it
    {passthrough_mode_i, mode_change_i} = 2'h3;
    step(1);
    mode_change_i = 1'b0;
    step(1);
    pins(8'h66);
    rdc(8'h12, 8'h01);
    removal_evt_i = 1'b1;
    step(1);
    {removal_evt_i, attach_evt_i} = 2'h1;
    step(1);
    attach_evt_i = 1'b0;
    rdc(8'h12, 8'h00);
    mode_select_first_i = 1'b0;
    step(2);
    mode_select_first_i = 1'b1;
    step(2);
    rdc(8'h12, 8'h01);
    finish_test;
  end
endmodule : test_cpsb_status_bank
